//--- logic/smc_defs.svh
// constants for the source-measure cycle sequencer
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH
`define SMC_CLK_HZ          40000000
`define SMC_TICK_NS         1000
`define SMC_CLK_NS          25
`define SMC_TICK_DIV        (`SMC_TICK_NS / `SMC_CLK_NS)
`define SMC_TICK_CNT_W      6
`define SMC_TIME_W          32
`define SMC_LEVEL_W         24
`define SMC_SRC_DLY_MIN_US  1
`define SMC_SRC_DLY_MAX_US  32'hD693A400
`define SMC_PW_MIN_US       100
`define SMC_PW_MAX_US       32'hD693A400
`define SMC_RELAY_SETTLE_US 1
`endif

//--- logic/smc_pkg.sv
// types for the source-measure cycle sequencer
package smc_pkg;
    typedef enum logic [3:0] {
        SMC_OFF      = 4'h0,
        SMC_RELAY_ON = 4'h1,
        SMC_IDLE     = 4'h2,
        SMC_SDLY     = 4'h3,
        SMC_MDLY     = 4'h4,
        SMC_MEAS     = 4'h5,
        SMC_PWAIT    = 4'h6,
        SMC_ZERO     = 4'h7
    } smc_state_e;
endpackage

//--- logic/smc_tick.sv
// timebase divider: one-cycle microsecond tick
`include "smc_defs.svh"
module smc_tick (
    input  wire logic clk,
    input  wire logic nrst,
    output logic      tick
);
    typedef struct packed {
        logic [`SMC_TICK_CNT_W-1:0] cnt;
        logic                       tick;
    } smc_tick_s;
    smc_tick_s r;
    smc_tick_s next_r;

    always_comb begin
        next_r = r;
        next_r.tick = 1'b0;
        if (r.cnt == `SMC_TICK_CNT_W'(`SMC_TICK_DIV - 1)) begin
            next_r.cnt = '0;
            next_r.tick = 1'b1;
        end else begin
            next_r.cnt = r.cnt + `SMC_TICK_CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tick = r.tick;
endmodule

//--- logic/smc_seq.sv
// source-measure cycle sequencer: delays, pulse, measurement, output relay
// Contract
// - trigger waits source delay, then applies level
// - measure delay follows level before measuring
// - dc cycle ends after measure and compute
// - new level applies at once, resets phase
// - without sweep, same level every cycle
// - dc, no measure: cycle ends at change
// - pulse and base levels, width 100us-3600s
// - pulse starts measure delay, base at end
// - pulse cycle ends at later of both
// - pulse, no measure: ends at pulse end
// - auto range uses larger magnitude
// - base accepts same range as level
// - source delay accepted 1us to 3600s
// - switch on: relay closes at zero first
// - switch off: zero level, then open relay
`include "smc_defs.svh"
module smc_seq (
    input  wire logic                    clk,
    input  wire logic                    nrst,
    input  wire logic                    trig_in,
    input  wire logic                    output_on,
    input  wire logic                    pulse_mode,
    input  wire logic                    meas_enable,
    input  wire logic                    level_write,
    input  wire logic [`SMC_LEVEL_W-1:0] src_level,
    input  wire logic [`SMC_LEVEL_W-1:0] base_level,
    input  wire logic [`SMC_TIME_W-1:0]  src_delay_us,
    input  wire logic [`SMC_TIME_W-1:0]  meas_delay_us,
    input  wire logic [`SMC_TIME_W-1:0]  pulse_width_us,
    input  wire logic                    meas_done,
    output logic [`SMC_LEVEL_W-1:0]      out_level,
    output logic [`SMC_LEVEL_W-1:0]      range_magnitude,
    output logic                         relay_closed,
    output logic                         meas_start,
    output logic                         cycle_done,
    output logic                         busy
);
    typedef struct packed {
        logic                    trig_q1;
        logic                    trig_q2;
        logic                    trig_q3;
        logic                    on_q1;
        logic                    on_q2;
        logic                    done_q1;
        logic                    done_q2;
        smc_pkg::smc_state_e     st;
        logic [`SMC_TIME_W-1:0]  dly;
        logic [`SMC_TIME_W-1:0]  pw;
        logic                    pulse_run;
        logic                    meas_run;
        logic [`SMC_LEVEL_W-1:0] level;
        logic [`SMC_LEVEL_W-1:0] rng;
        logic                    relay;
        logic                    mstart;
        logic                    cdone;
    } smc_seq_s;
    smc_seq_s r;
    smc_seq_s next_r;
    logic     tick;

    smc_tick u_tick (
        .clk  (clk),
        .nrst (nrst),
        .tick (tick)
    );

    function automatic logic [`SMC_LEVEL_W-1:0] mag(input logic [`SMC_LEVEL_W-1:0] v);
        mag = v[`SMC_LEVEL_W-1] ? (~v + `SMC_LEVEL_W'(1)) : v;
    endfunction

    // clamp a time setting into its legal window
    function automatic logic [`SMC_TIME_W-1:0] clamp(input logic [`SMC_TIME_W-1:0] v,
                                                     input logic [`SMC_TIME_W-1:0] lo,
                                                     input logic [`SMC_TIME_W-1:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    logic [`SMC_TIME_W-1:0] sdly_c;
    logic [`SMC_TIME_W-1:0] pw_c;
    logic                   trig_rise;
    logic                   pulse_end;
    assign sdly_c = clamp(src_delay_us, `SMC_TIME_W'(`SMC_SRC_DLY_MIN_US),
                          `SMC_TIME_W'(`SMC_SRC_DLY_MAX_US));
    assign pw_c = clamp(pulse_width_us, `SMC_TIME_W'(`SMC_PW_MIN_US),
                        `SMC_TIME_W'(`SMC_PW_MAX_US));

    always_comb begin
        next_r = r;
        next_r.trig_q1 = trig_in;
        next_r.trig_q2 = r.trig_q1;
        next_r.trig_q3 = r.trig_q2;
        next_r.on_q1 = output_on;
        next_r.on_q2 = r.on_q1;
        next_r.done_q1 = meas_done;
        next_r.done_q2 = r.done_q1;
        next_r.mstart = 1'b0;
        next_r.cdone = 1'b0;
        trig_rise = r.trig_q2 && !r.trig_q3;
        pulse_end = 1'b0;
        // base value shares the level's full signed range
        next_r.rng = (pulse_mode && mag(base_level) > mag(src_level))
                     ? mag(base_level) : mag(src_level);
        // pulse width runs beside the measure path
        if (r.pulse_run && tick) begin
            if (r.pw <= `SMC_TIME_W'(1)) begin
                next_r.pulse_run = 1'b0;
                next_r.level = base_level;
                pulse_end = 1'b1;
            end else begin
                next_r.pw = r.pw - `SMC_TIME_W'(1);
            end
        end
        case (r.st)
            smc_pkg::SMC_OFF: begin
                next_r.level = '0;
                next_r.relay = 1'b0;
                next_r.pulse_run = 1'b0;
                next_r.meas_run = 1'b0;
                if (r.on_q2) begin
                    next_r.relay = 1'b1;
                    next_r.dly = `SMC_TIME_W'(`SMC_RELAY_SETTLE_US);
                    next_r.st = smc_pkg::SMC_RELAY_ON;
                end
            end
            smc_pkg::SMC_RELAY_ON: begin
                // level stays zero for at least one full tick while contacts settle
                if (tick) begin
                    if (r.dly == '0) begin
                        next_r.level = pulse_mode ? base_level : src_level;
                        next_r.st = smc_pkg::SMC_IDLE;
                    end else begin
                        next_r.dly = r.dly - `SMC_TIME_W'(1);
                    end
                end
            end
            smc_pkg::SMC_IDLE: begin
                if (trig_rise) begin
                    next_r.dly = sdly_c;
                    next_r.st = smc_pkg::SMC_SDLY;
                end
            end
            smc_pkg::SMC_SDLY: begin
                // trigger is not tick aligned: one extra tick so the delay never runs short
                if (tick) begin
                    if (r.dly == '0) begin
                        // same level each cycle when not sweeping
                        next_r.level = src_level;
                        next_r.dly = meas_delay_us;
                        if (pulse_mode) begin
                            next_r.pw = pw_c;
                            next_r.pulse_run = 1'b1;
                        end
                        if (!meas_enable) begin
                            next_r.st = pulse_mode ? smc_pkg::SMC_PWAIT
                                                   : smc_pkg::SMC_IDLE;
                            next_r.cdone = !pulse_mode;
                        end else begin
                            next_r.st = smc_pkg::SMC_MDLY;
                        end
                    end else begin
                        next_r.dly = r.dly - `SMC_TIME_W'(1);
                    end
                end
            end
            smc_pkg::SMC_MDLY: begin
                if (tick) begin
                    if (r.dly == '0 || r.dly == `SMC_TIME_W'(1)) begin
                        next_r.mstart = 1'b1;
                        next_r.st = smc_pkg::SMC_MEAS;
                    end else begin
                        next_r.dly = r.dly - `SMC_TIME_W'(1);
                    end
                end
            end
            smc_pkg::SMC_MEAS: begin
                if (r.done_q2) begin
                    if (r.pulse_run && !pulse_end) begin
                        next_r.st = smc_pkg::SMC_PWAIT;
                    end else begin
                        next_r.cdone = 1'b1;
                        next_r.st = smc_pkg::SMC_IDLE;
                    end
                end
            end
            smc_pkg::SMC_PWAIT: begin
                if (!r.pulse_run || pulse_end) begin
                    next_r.cdone = 1'b1;
                    next_r.st = smc_pkg::SMC_IDLE;
                end
            end
            smc_pkg::SMC_ZERO: begin
                // one cycle at zero before the relay opens
                next_r.relay = 1'b0;
                next_r.st = smc_pkg::SMC_OFF;
            end
            default: begin
                next_r.st = smc_pkg::SMC_OFF;
            end
        endcase
        // direct level write: apply now, drop delays and trigger phase
        if (level_write && r.st != smc_pkg::SMC_OFF && r.st != smc_pkg::SMC_RELAY_ON
            && r.st != smc_pkg::SMC_ZERO) begin
            next_r.level = src_level;
            next_r.pulse_run = 1'b0;
            next_r.mstart = 1'b0;
            next_r.cdone = 1'b0;
            next_r.st = smc_pkg::SMC_IDLE;
        end
        if (!r.on_q2 && r.st != smc_pkg::SMC_OFF && r.st != smc_pkg::SMC_ZERO) begin
            next_r.level = '0;
            next_r.pulse_run = 1'b0;
            next_r.mstart = 1'b0;
            next_r.cdone = 1'b0;
            next_r.st = smc_pkg::SMC_ZERO;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign out_level = r.level;
    assign range_magnitude = r.rng;
    assign relay_closed = r.relay;
    assign meas_start = r.mstart;
    assign cycle_done = r.cdone;
    assign busy = (r.st != smc_pkg::SMC_IDLE) && (r.st != smc_pkg::SMC_OFF);
endmodule

//--- verification/smc_seq_chk.sv
// port-level assertions for the cycle sequencer
`include "smc_defs.svh"
module smc_seq_chk (
    input wire logic                    clk,
    input wire logic                    nrst,
    input wire logic                    trig_in,
    input wire logic                    pulse_mode,
    input wire logic                    meas_enable,
    input wire logic                    level_write,
    input wire logic [`SMC_LEVEL_W-1:0] src_level,
    input wire logic [`SMC_LEVEL_W-1:0] base_level,
    input wire logic [`SMC_LEVEL_W-1:0] out_level,
    input wire logic [`SMC_LEVEL_W-1:0] range_magnitude,
    input wire logic                    relay_closed,
    input wire logic                    meas_start,
    input wire logic                    cycle_done,
    input wire logic                    busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    function automatic logic [`SMC_LEVEL_W-1:0] mag(input logic [`SMC_LEVEL_W-1:0] v);
        return v[`SMC_LEVEL_W-1] ? -v : v;
    endfunction
    relay_zero_a: assert property ($rose(relay_closed) |-> (out_level == 0)[*8])
        else $error("relay closed off zero");
    off_zero_a: assert property ($fell(relay_closed) |-> out_level == 0 && $past(out_level) == 0)
        else $error("relay opened off zero");
    off_quiet_a: assert property (!relay_closed && !$past(relay_closed) |-> !meas_start && !cycle_done)
        else $error("cycle activity while off");
    meas_pulse_a: assert property (meas_start |-> meas_enable && busy ##1 !meas_start)
        else $error("bad measure start");
    done_pulse_a: assert property (cycle_done |=> !cycle_done && !busy)
        else $error("bad cycle end");
    trig_hold_a: assert property ($rose(trig_in) && !busy && relay_closed |=> $stable(out_level)[*8])
        else $error("level moved before source delay");
    lw_apply_a: assert property (level_write && busy && relay_closed |=> out_level == $past(src_level) && !busy)
        else $error("written level not applied");
    // stable inputs only: the output is registered one clock behind
    range_pick_a: assert property ($past(nrst) && $stable(pulse_mode) && $stable(src_level) && $stable(base_level)
        |-> range_magnitude == (pulse_mode && mag(base_level) > mag(src_level) ? mag(base_level) : mag(src_level)))
        else $error("wrong range magnitude");
    cover property (meas_start);
    cover property (cycle_done && pulse_mode);
    cover property ($fell(relay_closed));
endmodule
bind smc_seq smc_seq_chk u_chk (.clk(clk), .nrst(nrst), .trig_in(trig_in), .pulse_mode(pulse_mode),
    .meas_enable(meas_enable), .level_write(level_write), .src_level(src_level),
    .base_level(base_level), .out_level(out_level), .range_magnitude(range_magnitude),
    .relay_closed(relay_closed), .meas_start(meas_start), .cycle_done(cycle_done), .busy(busy));

//--- verification/smc_meas_model.sv
// measurement unit model: answers each start after a set latency
module smc_meas_model (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic meas_start,
    input  wire logic [31:0] lat,
    output logic      meas_done
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    always_ff @(posedge clk) begin
        if (!nrst)
            cnt <= 0;
        else if (meas_start)
            cnt <= int'(lat) + 4;
        else if (cnt != 0)
            cnt <= cnt - 1;
    end
    // held four clocks so the input synchroniser cannot miss it
    assign meas_done = cnt > 0 && cnt <= 4;
endmodule

//--- verification/tb_smc_seq.sv
// self-checking bench for the cycle sequencer
`include "smc_defs.svh"
module tb_smc_seq;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, nrst = 0, trig_in = 0, output_on = 0, pulse_mode = 0, meas_enable = 1;
    logic level_write = 0, meas_done, relay_closed, meas_start, cycle_done, busy;
    logic [`SMC_LEVEL_W-1:0] src_level = 24'h000123, base_level = 24'h000800;
    logic [`SMC_LEVEL_W-1:0] out_level, range_magnitude;
    logic [`SMC_TIME_W-1:0] src_delay_us = 32'h3, meas_delay_us = 32'h2, pulse_width_us = 32'h32;
    int lat = 100, err_count = 0, checks_done = 0, tl, tm, td, tb, tq;
    smc_seq uut (.clk(clk), .nrst(nrst), .trig_in(trig_in), .output_on(output_on),
        .pulse_mode(pulse_mode), .meas_enable(meas_enable), .level_write(level_write),
        .src_level(src_level), .base_level(base_level), .src_delay_us(src_delay_us),
        .meas_delay_us(meas_delay_us), .pulse_width_us(pulse_width_us), .meas_done(meas_done),
        .out_level(out_level), .range_magnitude(range_magnitude), .relay_closed(relay_closed),
        .meas_start(meas_start), .cycle_done(cycle_done), .busy(busy));
    smc_meas_model mu (.clk(clk), .nrst(nrst), .meas_start(meas_start), .lat(lat),
        .meas_done(meas_done));
    initial begin
        forever #12.5 clk = ~clk;
    end
    function automatic logic inr(int x, int a, int b);
        return x >= a && x <= b;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    // one triggered cycle; event times in clocks from the trigger edge
    task automatic cyc(input logic [`SMC_LEVEL_W-1:0] lv);
        tl = 0; tm = 0; td = 0; tb = 0; tq = 0;
        for (int n = 1; n < 8000 && td == 0; n++) begin
            @(negedge clk);
            trig_in = (n < 5);
            if (tl == 0 && out_level === lv) tl = n;
            if (meas_start === 1'b1) tm = n;
            if (tq == 0 && meas_done === 1'b1) tq = n;
            if (cycle_done === 1'b1) td = n;
            if (tl != 0 && tb == 0 && pulse_mode && out_level === base_level) tb = n;
        end
        chk("cycle_end", td != 0, 1);
        $display("cycle test done after %0d clocks", td);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #1000000;
        err_count++;
        results;
    end
    initial begin
        repeat (10) @(negedge clk);
        nrst = 1;
        chk("reset_out", {relay_closed, busy, out_level}, 0);
        output_on = 1;
        repeat (4) @(negedge clk);
        chk("relay_on", {relay_closed, out_level}, 25'h1000000);
        repeat (80) @(negedge clk);
        chk("on_level", out_level, src_level);
        $display("switch on test done");
        src_level = 24'h000456;
        cyc(src_level);
        chk("src_delay", inr(tl, 124, 165), 1);
        chk("meas_delay", inr(tm - tl, 80, 81), 1);
        chk("dc_done", inr(td - tq, 1, 6), 1);
        cyc(src_level);
        chk("hold_level", out_level, src_level);
        meas_enable = 0;
        src_level = 24'h000789;
        src_delay_us = 32'h0;
        cyc(src_level);
        chk("nomeas", {tm == 0, inr(td - tl, -1, 1)}, 2'b11);
        chk("min_delay", inr(tl, 44, 85), 1);
        pulse_mode = 1;
        meas_enable = 1;
        src_level = 24'hFFF000;
        repeat (10) @(negedge clk);
        chk("range", range_magnitude, 24'h001000);
        cyc(src_level);
        chk("pulse_width", inr(tb - tl, 3960, 4010), 1);
        chk("pulse_meas", inr(tm - tl, 80, 81), 1);
        chk("pulse_end", inr(td - tb, 0, 2), 1);
        lat = 6000;
        cyc(src_level);
        chk("late_meas", {tb < tq, inr(td - tq, 1, 6)}, 2'b11);
        meas_enable = 0;
        cyc(src_level);
        chk("pulse_nomeas", {tm == 0, inr(td - tb, 0, 2)}, 2'b11);
        pulse_mode = 0;
        src_delay_us = 32'h32;
        trig_in = 1;
        repeat (200) @(negedge clk);
        src_level = 24'h000ABC;
        level_write = 1;
        @(negedge clk);
        level_write = 0;
        trig_in = 0;
        chk("lw_apply", {busy, out_level}, 25'h0000ABC);
        output_on = 0;
        repeat (3) @(negedge clk);
        chk("off_zero", {relay_closed, out_level}, 25'h1000000);
        @(negedge clk);
        chk("off_relay", relay_closed, 0);
        $display("switch off test done");
        results;
    end
endmodule
